//--- rtl/ppom_cfg.svh
// ppom_cfg.svh: offsets, field positions, reset values and sizes of the port pin override mux
// assumes: included by the package and the top module by bare name
`ifndef PPOM_CFG_SVH
`define PPOM_CFG_SVH

// ----------------------------------------------------------------
// sizes
// ----------------------------------------------------------------
`define PPOM_PINS 8
`define PPOM_AW 12
`define PPOM_DW 32

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define PPOM_OFF_DIR 12'h000
`define PPOM_OFF_OUT 12'h004
`define PPOM_OFF_IN 12'h008
`define PPOM_OFF_CTRL 12'h00c
`define PPOM_OFF_STAT 12'h010

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PPOM_CTRL_PUD_BIT 0
`define PPOM_CTRL_EME_BIT 1
`define PPOM_STAT_OE_LSB 0
`define PPOM_STAT_PU_LSB 8
`define PPOM_STAT_IE_LSB 16

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define PPOM_RST_DIR 8'h00
`define PPOM_RST_OUT 8'h00
`define PPOM_RST_CTRL 2'h0
`define PPOM_RESP_OKAY 2'h0
`define PPOM_RESP_SLVERR 2'h2

`endif

//--- rtl/ppom_pkg.sv
// ppom_pkg: bus and override carrier types of the port pin override mux
// assumes: ppom_cfg.svh on the include path
`include "ppom_cfg.svh"

package ppom_pkg;

  // ----------------------------------------------------------------
  // axi4-lite carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [`PPOM_AW-1:0] awaddr;
    logic [2:0] awprot;
    logic wvalid;
    logic [`PPOM_DW-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [`PPOM_AW-1:0] araddr;
    logic [2:0] arprot;
    logic rready;
  } ppom_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [`PPOM_DW-1:0] rdata;
    logic [1:0] rresp;
  } ppom_axi_rsp_type;

  // ----------------------------------------------------------------
  // per-pin overrides from an alternate-function module
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [`PPOM_PINS-1:0] pullup_override_en;
    logic [`PPOM_PINS-1:0] pullup_override_val;
    logic [`PPOM_PINS-1:0] dir_override_en;
    logic [`PPOM_PINS-1:0] dir_override_val;
    logic [`PPOM_PINS-1:0] value_override_en;
    logic [`PPOM_PINS-1:0] value_override_val;
    logic [`PPOM_PINS-1:0] toggle_override_en;
    logic [`PPOM_PINS-1:0] input_enable_override_en;
    logic [`PPOM_PINS-1:0] input_enable_override_val;
  } ppom_ovr_type;

  // external memory interface, low address / data byte
  typedef struct packed {
    logic port_write_strobe;
    logic address_phase_active;
    logic [`PPOM_PINS-1:0] addr_low;
    logic [`PPOM_PINS-1:0] data_out;
  } ppom_mem_type;

  // pad side outputs
  typedef struct packed {
    logic [`PPOM_PINS-1:0] pad_out;
    logic [`PPOM_PINS-1:0] pad_oe_n;
    logic [`PPOM_PINS-1:0] pullup_on;
    logic [`PPOM_PINS-1:0] input_en;
  } ppom_pad_type;

endpackage

//--- rtl/ppom_port_mux.sv
// ppom_port_mux: one eight-pin port with alternate-function overrides and the
// external memory low address/data byte mapping, registers over axi4-lite
// assumes: single clock, synchronous active-low reset, pad and peripheral
// inputs synchronous to clk, analog path finished in the pad ring
//
// Overview of operation
// - pull-up follows override value when enabled, else on for dir/out/pud 0b010
// - enabled pull-up override ignores output bit and global disable; pad pull-up still gated off while the driver is on
// - driver enable from direction override value when enabled, else direction bit
// - direction override on: driver on for high value, off for low
// - driven level from value override when enabled, else output bit
// - value override enabled: pad value equals override value while the driver is on, output bit ignored
// - toggle override enable inverts the stored output bit
// - input enable from override when enabled, else from normal/sleep state
// - input enable override value high enables, low disables, regardless of sleep
// - raw input to peripherals taken after input clamp, before read synchroniser
// - analog path: pad level registered into analog_pad_link, analog drive reaches the pad only with the driver off
// - each port pin carries matching external memory address/data bit
// - memory enable drives pull-up, direction and value override enables
// - memory direction override high during write or address phase
// - address phase outputs low address bit, write outputs data bit
// - memory pull-up only when idle, output bit set and pull-ups allowed
// - no input enable override for memory; raw input is memory data in
// - strobes, clock, sleep, pull-up disable shared; overrides per pin
// - global pull-up disable switches every default pull-up off
// - writing one to input register bit inverts the output bit
`timescale 1ns/1ns
`include "ppom_cfg.svh"

module ppom_port_mux (
  // clock, reset, enable
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // register bus
  input wire ppom_pkg::ppom_axi_req_type axi_req,
  output ppom_pkg::ppom_axi_rsp_type axi_rsp,
  // alternate-function overrides
  input wire ppom_pkg::ppom_ovr_type alt_ovr,
  // external memory interface
  input wire ppom_pkg::ppom_mem_type mem_req,
  // global and sleep state
  input wire logic sleep,
  // pad
  input wire logic [`PPOM_PINS-1:0] pad_in,
  input wire logic [`PPOM_PINS-1:0] analog_drive_en,
  input wire logic [`PPOM_PINS-1:0] analog_drive_val,
  output ppom_pkg::ppom_pad_type pad,
  // inputs offered to alternate functions and memory data in
  output logic [`PPOM_PINS-1:0] alt_raw_input,
  output logic [`PPOM_PINS-1:0] analog_pad_link
);
  import ppom_pkg::*;

  localparam int N = `PPOM_PINS;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [N-1:0] pin_direction_bit_r;
  logic [N-1:0] pin_output_bit_r;
  logic [N-1:0] pin_output_bit_nxt;
  logic [N-1:0] pin_input_bit_r;
  logic [N-1:0] sync_stage_r;
  logic global_pullup_disable_r;
  logic ext_mem_enable_r;
  logic mem_wr_r;
  logic mem_ada_r;
  logic [N-1:0] mem_addr_r;
  logic [N-1:0] mem_dout_r;
  ppom_pad_type pad_r;
  logic [N-1:0] alt_raw_r;
  logic [N-1:0] analog_link_r;

  // effective overrides
  logic [N-1:0] pu_oe;
  logic [N-1:0] pu_ov;
  logic [N-1:0] dd_oe;
  logic [N-1:0] dd_ov;
  logic [N-1:0] pv_oe;
  logic [N-1:0] pv_ov;
  logic [N-1:0] pt_oe;
  logic [N-1:0] ie_oe;
  logic [N-1:0] ie_ov;
  logic [N-1:0] drv_en;
  logic [N-1:0] drv_val;
  logic [N-1:0] pullup_nxt;
  logic [N-1:0] in_en_nxt;
  logic [N-1:0] clamped_in;
  logic mem_drive;

  // bus
  logic aw_got_r;
  logic w_got_r;
  logic [`PPOM_AW-1:0] aw_addr_r;
  logic [`PPOM_DW-1:0] w_data_r;
  logic [3:0] w_strb_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [`PPOM_DW-1:0] rdata_r;
  logic [1:0] rresp_r;
  logic aw_fire;
  logic w_fire;
  logic ar_fire;
  logic wr_do;
  logic [`PPOM_AW-1:0] wr_addr;
  logic [`PPOM_DW-1:0] wr_data;
  logic wr_lane0;
  logic wr_hit;
  logic [`PPOM_DW-1:0] rd_data;
  logic rd_hit;

  // ----------------------------------------------------------------
  // axi4-lite handshakes
  // ----------------------------------------------------------------
  assign aw_fire = axi_req.awvalid & awready_r;
  assign w_fire = axi_req.wvalid & wready_r;
  assign ar_fire = axi_req.arvalid & arready_r;

  // write happens once both halves are in, taken live or from the holding regs
  assign wr_do = (aw_got_r | aw_fire) & (w_got_r | w_fire) & ~bvalid_r;
  assign wr_addr = aw_got_r ? aw_addr_r : axi_req.awaddr;
  assign wr_data = w_got_r ? w_data_r : axi_req.wdata;
  assign wr_lane0 = w_got_r ? w_strb_r[0] : axi_req.wstrb[0];

  // write address and data capture, in either order
  always_ff @(posedge clk) begin
    if (!resetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= 4'h0;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
    end else if (ce) begin
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        awready_r <= 1'b0;
        wready_r <= 1'b0;
      end else begin
        if (aw_fire) begin
          aw_got_r <= 1'b1;
          aw_addr_r <= axi_req.awaddr;
          awready_r <= 1'b0;
        end
        if (w_fire) begin
          w_got_r <= 1'b1;
          w_data_r <= axi_req.wdata;
          w_strb_r <= axi_req.wstrb;
          wready_r <= 1'b0;
        end
        if (bvalid_r && axi_req.bready) begin
          awready_r <= 1'b1;
          wready_r <= 1'b1;
        end
      end
    end
  end

  // write decode
  always_comb begin
    wr_hit = 1'b0;
    unique case (wr_addr)
      `PPOM_OFF_DIR, `PPOM_OFF_OUT, `PPOM_OFF_IN, `PPOM_OFF_CTRL, `PPOM_OFF_STAT: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // write response
  always_ff @(posedge clk) begin
    if (!resetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `PPOM_RESP_OKAY;
    end else if (ce) begin
      if (wr_do) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_hit ? `PPOM_RESP_OKAY : `PPOM_RESP_SLVERR;
      end else if (bvalid_r && axi_req.bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // read decode, state registers read back live
  always_comb begin
    rd_data = '0;
    rd_hit = 1'b1;
    unique case (axi_req.araddr)
      `PPOM_OFF_DIR: rd_data[N-1:0] = pin_direction_bit_r;
      `PPOM_OFF_OUT: rd_data[N-1:0] = pin_output_bit_r;
      `PPOM_OFF_IN: rd_data[N-1:0] = pin_input_bit_r;
      `PPOM_OFF_CTRL: begin
        rd_data[`PPOM_CTRL_PUD_BIT] = global_pullup_disable_r;
        rd_data[`PPOM_CTRL_EME_BIT] = ext_mem_enable_r;
      end
      `PPOM_OFF_STAT: begin
        rd_data[`PPOM_STAT_OE_LSB +: N] = ~pad_r.pad_oe_n;
        rd_data[`PPOM_STAT_PU_LSB +: N] = pad_r.pullup_on;
        rd_data[`PPOM_STAT_IE_LSB +: N] = pad_r.input_en;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read channel
  always_ff @(posedge clk) begin
    if (!resetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= `PPOM_RESP_OKAY;
    end else if (ce) begin
      if (ar_fire) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_data;
        rresp_r <= rd_hit ? `PPOM_RESP_OKAY : `PPOM_RESP_SLVERR;
      end else if (rvalid_r && axi_req.rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end

  assign axi_rsp.awready = awready_r;
  assign axi_rsp.wready = wready_r;
  assign axi_rsp.bvalid = bvalid_r;
  assign axi_rsp.bresp = bresp_r;
  assign axi_rsp.arready = arready_r;
  assign axi_rsp.rvalid = rvalid_r;
  assign axi_rsp.rdata = rdata_r;
  assign axi_rsp.rresp = rresp_r;

  // ----------------------------------------------------------------
  // port registers
  // ----------------------------------------------------------------
  // direction and control, shared strobe for the whole port
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_direction_bit_r <= `PPOM_RST_DIR;
      global_pullup_disable_r <= 1'(`PPOM_RST_CTRL);
      ext_mem_enable_r <= 1'b0;
    end else if (ce && wr_do && wr_lane0) begin
      if (wr_addr == `PPOM_OFF_DIR) begin
        pin_direction_bit_r <= wr_data[N-1:0];
      end
      if (wr_addr == `PPOM_OFF_CTRL) begin
        global_pullup_disable_r <= wr_data[`PPOM_CTRL_PUD_BIT];
        ext_mem_enable_r <= wr_data[`PPOM_CTRL_EME_BIT];
      end
    end
  end

  // output bit: write, software toggle, then hardware toggle on top
  always_comb begin
    pin_output_bit_nxt = pin_output_bit_r;
    if (wr_do && wr_lane0 && wr_addr == `PPOM_OFF_OUT) begin
      pin_output_bit_nxt = wr_data[N-1:0];
    end
    if (wr_do && wr_lane0 && wr_addr == `PPOM_OFF_IN) begin
      pin_output_bit_nxt = pin_output_bit_r ^ wr_data[N-1:0];
    end
    pin_output_bit_nxt = pin_output_bit_nxt ^ pt_oe;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      pin_output_bit_r <= `PPOM_RST_OUT;
    end else if (ce) begin
      pin_output_bit_r <= pin_output_bit_nxt;
    end
  end

  // ----------------------------------------------------------------
  // external memory qualifiers
  // ----------------------------------------------------------------
  // sampled so the pin muxing only changes on clock edges
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mem_wr_r <= 1'b0;
      mem_ada_r <= 1'b0;
      mem_addr_r <= '0;
      mem_dout_r <= '0;
    end else if (ce) begin
      mem_wr_r <= mem_req.port_write_strobe;
      mem_ada_r <= mem_req.address_phase_active;
      mem_addr_r <= mem_req.addr_low;
      mem_dout_r <= mem_req.data_out;
    end
  end

  assign mem_drive = mem_wr_r | mem_ada_r;

  // ----------------------------------------------------------------
  // override selection, bitwise per pin
  // ----------------------------------------------------------------
  // memory enable takes the whole byte, bit n to pin n
  always_comb begin
    if (ext_mem_enable_r) begin
      pu_oe = '1;
      pu_ov = {N{~mem_drive & ~global_pullup_disable_r}} & pin_output_bit_r;
      dd_oe = '1;
      dd_ov = {N{mem_drive}};
      pv_oe = '1;
      pv_ov = (mem_addr_r & {N{mem_ada_r}}) | (mem_dout_r & {N{mem_wr_r}});
      pt_oe = '0;
      ie_oe = '0;
      ie_ov = '0;
    end else begin
      pu_oe = alt_ovr.pullup_override_en;
      pu_ov = alt_ovr.pullup_override_val;
      dd_oe = alt_ovr.dir_override_en;
      dd_ov = alt_ovr.dir_override_val;
      pv_oe = alt_ovr.value_override_en;
      pv_ov = alt_ovr.value_override_val;
      pt_oe = alt_ovr.toggle_override_en;
      ie_oe = alt_ovr.input_enable_override_en;
      ie_ov = alt_ovr.input_enable_override_val;
    end
  end

  // pin control equations, overrides per pin, sleep and disable shared
  always_comb begin
    pullup_nxt = (pu_oe & pu_ov) |
      (~pu_oe & ~pin_direction_bit_r & pin_output_bit_r & {N{~global_pullup_disable_r}});
    drv_en = (dd_oe & dd_ov) | (~dd_oe & pin_direction_bit_r);
    drv_val = (pv_oe & pv_ov) | (~pv_oe & pin_output_bit_r);
    in_en_nxt = (ie_oe & ie_ov) | (~ie_oe & {N{~sleep}});
    clamped_in = pad_in & pad_r.input_en;
  end

  // ----------------------------------------------------------------
  // pad outputs
  // ----------------------------------------------------------------
  // analog level only shows on an idle pin; oe_n follows the digital driver alone
  always_ff @(posedge clk) begin
    if (!resetn) begin
      pad_r.pad_out <= '0;
      pad_r.pad_oe_n <= '1;
      pad_r.pullup_on <= '0;
      pad_r.input_en <= '0;
    end else if (ce) begin
      pad_r.pad_out <= (drv_en & drv_val) | (~drv_en & analog_drive_en & analog_drive_val);
      pad_r.pad_oe_n <= ~drv_en;
      pad_r.pullup_on <= pullup_nxt & ~drv_en;
      pad_r.input_en <= in_en_nxt;
    end
  end

  assign pad = pad_r;

  // ----------------------------------------------------------------
  // input paths
  // ----------------------------------------------------------------
  // raw tap for peripherals and memory data in, ahead of the synchroniser
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alt_raw_r <= '0;
      analog_link_r <= '0;
    end else if (ce) begin
      alt_raw_r <= clamped_in;
      analog_link_r <= pad_in;
    end
  end

  // two-stage read synchroniser into the input register
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sync_stage_r <= '0;
      pin_input_bit_r <= '0;
    end else if (ce) begin
      sync_stage_r <= clamped_in;
      pin_input_bit_r <= sync_stage_r;
    end
  end

  assign alt_raw_input = alt_raw_r;
  assign analog_pad_link = analog_link_r;

endmodule

//--- tb/port_pin_override_mux_bench.sv
// port_pin_override_mux_bench: self-checking bench for ppom_port_mux
// assumes: ppom_alt_partner drives overrides and memory requests
`timescale 1ns/1ns
`include "ppom_cfg.svh"

module port_pin_override_mux_bench;
  import ppom_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sleep = 1'b0;
  logic load = 1'b0;
  logic ovr_on = 1'b0;
  logic [7:0] tog = 8'h00;
  logic [7:0] pad_in = 8'h00;
  logic [7:0] an_en = 8'h00;
  logic [7:0] an_val = 8'h00;
  logic [31:0] rnd = 32'h0;
  logic [31:0] seed = 32'h7715;
  logic [31:0] e;
  logic [7:0] raw, alink, dir_m, out_m;
  logic pud_m, eme_m;
  ppom_axi_req_type req = '0;
  ppom_axi_rsp_type rsp;
  ppom_ovr_type ovr;
  ppom_mem_type mem;
  ppom_pad_type pad;
  int bad_count = 0;
  int compares = 0;

  // 25 MHz clock
  always #20 clk = ~clk;

  ppom_port_mux uut (.clk(clk), .resetn(resetn), .ce(1'b1), .axi_req(req), .axi_rsp(rsp), .alt_ovr(ovr),
    .mem_req(mem), .sleep(sleep), .pad_in(pad_in), .analog_drive_en(an_en), .analog_drive_val(an_val),
    .pad(pad), .alt_raw_input(raw), .analog_pad_link(alink));
  ppom_alt_partner far (.clk(clk), .resetn(resetn), .rnd(rnd), .load(load), .ovr_on(ovr_on), .tog(tog),
    .alt_ovr(ovr), .mem_req(mem), .raw_in(raw), .raw_sync());

  // --------
  // helpers
  // --------
  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // axi4-lite write, address and data offered together
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n = 0;
    logic aw_t, w_t, b_t;
    logic [1:0] resp;
    @(posedge clk);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(negedge clk);
      aw_t = req.awvalid & rsp.awready;
      w_t = req.wvalid & rsp.wready;
      b_t = rsp.bvalid;
      resp = rsp.bresp;
      @(posedge clk);
      if (aw_t) req.awvalid <= 1'b0;
      if (w_t) req.wvalid <= 1'b0;
      if (++n > 100) begin
        bad_count++;
        tally_and_finish();
      end
    end while (b_t !== 1'b1);
    req.bready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
  endtask

  // axi4-lite read, data compared only on an okay answer
  task automatic axi_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n = 0;
    logic ar_t, r_t;
    logic [1:0] resp;
    logic [31:0] data;
    @(posedge clk);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(negedge clk);
      ar_t = req.arvalid & rsp.arready;
      r_t = rsp.rvalid;
      resp = rsp.rresp;
      data = rsp.rdata;
      @(posedge clk);
      if (ar_t) req.arvalid <= 1'b0;
      if (++n > 100) begin
        bad_count++;
        tally_and_finish();
      end
    end while (r_t !== 1'b1);
    req.rready <= 1'b0;
    chk({30'h0, resp}, {30'h0, er});
    if (er == `PPOM_RESP_OKAY) chk(data, ed);
  endtask

  // expected {level, oe_n, pull-up, input enable}
  function automatic logic [31:0] model();
    logic [7:0] a, oe, pu;
    a = {8{mem.port_write_strobe | mem.address_phase_active}};
    oe = eme_m ? a : ovr.dir_override_en & ovr.dir_override_val | ~ovr.dir_override_en & dir_m;
    pu = eme_m ? ~a & out_m & {8{!pud_m}} : ovr.pullup_override_en & ovr.pullup_override_val
      | ~ovr.pullup_override_en & ~dir_m & out_m & {8{!pud_m}};
    return {oe & (eme_m ? mem.addr_low & {8{mem.address_phase_active}} | mem.data_out & {8{mem.port_write_strobe}}
      : ovr.value_override_en & ovr.value_override_val | ~ovr.value_override_en & out_m), ~oe, pu & ~oe,
      eme_m ? {8{!sleep}} : ovr.input_enable_override_en & ovr.input_enable_override_val
      | ~ovr.input_enable_override_en & {8{!sleep}}};
  endfunction

  task automatic check_pins();
    e = model();
    chk({pad.pad_out & ~pad.pad_oe_n, pad.pad_oe_n, pad.pullup_on, pad.input_en}, e);
    chk({24'h0, raw}, {24'h0, pad_in & e[7:0]});
    chk({24'h0, alink}, {24'h0, pad_in});
    axi_rd(`PPOM_OFF_STAT, {8'h00, e[7:0], e[15:8], ~e[23:16]}, `PPOM_RESP_OKAY);
    axi_rd(`PPOM_OFF_IN, {24'h0, pad_in & e[7:0]}, `PPOM_RESP_OKAY);
    axi_rd(`PPOM_OFF_OUT, {24'h0, out_m}, `PPOM_RESP_OKAY);
  endtask

  // --------
  // main sequence: plain, overrides, memory, plain again
  // --------
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    {dir_m, out_m, pud_m, eme_m} = '0;
    repeat (3) @(posedge clk);
    check_pins();
    for (int i = 0; i < 48; i++) begin
      seed = lfsr(seed);
      dir_m = seed[7:0];
      pud_m = seed[8];
      eme_m = (i / 12 == 2);
      axi_wr(`PPOM_OFF_DIR, {24'h0, dir_m}, `PPOM_RESP_OKAY);
      axi_wr(`PPOM_OFF_OUT, {24'h0, seed[23:16]}, `PPOM_RESP_OKAY);
      axi_wr(`PPOM_OFF_IN, {24'h0, seed[31:24]}, `PPOM_RESP_OKAY);
      out_m = seed[23:16] ^ seed[31:24];
      axi_wr(`PPOM_OFF_CTRL, {30'h0, eme_m, pud_m}, `PPOM_RESP_OKAY);
      seed = lfsr(seed);
      @(posedge clk);
      rnd <= seed;
      load <= 1'b1;
      ovr_on <= (i / 12 % 3 != 0);
      tog <= (i / 12 == 1) ? seed[9:2] : 8'h00;
      sleep <= seed[5];
      pad_in <= seed[31:24];
      an_en <= seed[23:16];
      an_val <= seed[15:8];
      @(posedge clk);
      load <= 1'b0;
      if (i / 12 == 1) out_m = out_m ^ seed[9:2];
      repeat (3) @(posedge clk);
      check_pins();
    end
    axi_wr(12'h014, 32'hffff_ffff, `PPOM_RESP_SLVERR);
    axi_rd(12'h014, 32'h0, `PPOM_RESP_SLVERR);
    axi_rd(`PPOM_OFF_DIR, {24'h0, dir_m}, `PPOM_RESP_OKAY);
    tally_and_finish();
  end
endmodule

//--- tb/ppom_alt_partner.sv
// ppom_alt_partner: alternate-function side, drives overrides and memory requests
// assumes: bench supplies random words and one-cycle load strobes on clk
`timescale 1ns/1ns

module ppom_alt_partner (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // control from the bench
  input wire logic [31:0] rnd,
  input wire logic load,
  input wire logic ovr_on,
  input wire logic [7:0] tog,
  // towards the port
  output ppom_pkg::ppom_ovr_type alt_ovr,
  output ppom_pkg::ppom_mem_type mem_req,
  // raw input back from the port
  input wire logic [7:0] raw_in,
  output logic [7:0] raw_sync
);
  import ppom_pkg::*;
  logic [7:0] raw_meta;

  // overrides made by the owning function, toggle lasts one cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      alt_ovr <= '0;
      mem_req <= '0;
    end else if (load) begin
      alt_ovr <= {rnd, ~rnd, rnd[15:8]} & {72{ovr_on}} & ~(72'hff << 16) | {48'h0, tog, 16'h0};
      mem_req <= rnd[17:0] ^ rnd[31:14];
    end else begin
      alt_ovr.toggle_override_en <= 8'h00;
    end
  end

  // own synchroniser on the raw input
  always_ff @(posedge clk) begin
    raw_meta <= raw_in;
    raw_sync <= raw_meta;
  end
endmodule

//--- tb/ppom_port_mux_monitor.sv
// ppom_port_mux_monitor: pin-level assertions for ppom_port_mux
// assumes: the bus master offers write address and data together
`timescale 1ns/1ns
`include "ppom_cfg.svh"

module ppom_port_mux_monitor (
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  // bus, overrides, memory, sleep
  input wire ppom_pkg::ppom_axi_req_type axi_req,
  input wire ppom_pkg::ppom_axi_rsp_type axi_rsp,
  input wire ppom_pkg::ppom_ovr_type alt_ovr,
  input wire ppom_pkg::ppom_mem_type mem_req,
  input wire logic sleep,
  // pad side
  input wire logic [`PPOM_PINS-1:0] pad_in,
  input wire ppom_pkg::ppom_pad_type pad,
  input wire logic [`PPOM_PINS-1:0] alt_raw_input,
  input wire logic [`PPOM_PINS-1:0] analog_pad_link
);
  import ppom_pkg::*;
  logic eme_r, pud_r, sleep_q;
  logic [7:0] pin_q, ie_q, act_qq;
  ppom_ovr_type ovr_q;
  ppom_mem_type mem_q, mem_qq;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  // --------
  // helper state
  // --------
  // control bits copied from bus writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      eme_r <= 1'b0;
      pud_r <= 1'b0;
    end else if (ce && axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready
        && axi_req.awaddr == `PPOM_OFF_CTRL && axi_req.wstrb[0]) begin
      eme_r <= axi_req.wdata[`PPOM_CTRL_EME_BIT];
      pud_r <= axi_req.wdata[`PPOM_CTRL_PUD_BIT];
    end
  end

  // inputs one and two cycles back
  always_ff @(posedge clk) begin
    ovr_q <= alt_ovr;
    mem_q <= mem_req;
    mem_qq <= mem_q;
    sleep_q <= sleep;
    pin_q <= pad_in;
    ie_q <= pad.input_en;
  end
  assign act_qq = {8{mem_qq.port_write_strobe | mem_qq.address_phase_active}};

  // --------
  // assertions
  // --------
  a_dir_ovr_drive: assert property (
    !eme_r |=> ((pad.pad_oe_n ^ ~ovr_q.dir_override_val) & ovr_q.dir_override_en) == 8'h00)
    else $error("driver enable ignores direction override");
  a_val_ovr_level: assert property (
    !eme_r |=> ((pad.pad_out ^ ovr_q.value_override_val) & ovr_q.value_override_en & ~pad.pad_oe_n) == 8'h00)
    else $error("driven level ignores value override");
  a_pu_ovr_follow: assert property (
    !eme_r |=> ((pad.pullup_on ^ ovr_q.pullup_override_val) & ovr_q.pullup_override_en & pad.pad_oe_n) == 8'h00)
    else $error("pull-up ignores override");
  a_ie_ovr_select: assert property (
    !eme_r |=> pad.input_en == (ovr_q.input_enable_override_en & ovr_q.input_enable_override_val
      | ~ovr_q.input_enable_override_en & {8{!sleep_q}}))
    else $error("input enable wrong");
  a_mem_ie_plain: assert property (
    eme_r |=> pad.input_en == {8{!sleep_q}})
    else $error("memory mode overrides input enable");
  a_mem_dir_phase: assert property (
    eme_r |=> pad.pad_oe_n == ~act_qq)
    else $error("memory direction wrong");
  a_mem_out_bits: assert property (
    eme_r && mem_req == mem_q && mem_q == mem_qq |=> (pad.pad_out & ~pad.pad_oe_n) ==
      (mem_qq.addr_low & {8{mem_qq.address_phase_active}} | mem_qq.data_out & {8{mem_qq.port_write_strobe}}))
    else $error("memory byte not on pins");
  a_pud_kills_pu: assert property (
    pud_r |=> (pad.pullup_on & ~(ovr_q.pullup_override_en & {8{!$past(eme_r)}})) == 8'h00)
    else $error("pull-up on while disabled");
  a_raw_after_ie: assert property (
    resetn |=> alt_raw_input == (pin_q & ie_q))
    else $error("raw input wrong");
  a_analog_copy: assert property (
    resetn |=> analog_pad_link == $past(pad_in))
    else $error("analog link wrong");

  // main scenarios
  c_mem_addr: cover property (eme_r && mem_req.address_phase_active);
  c_toggle: cover property (!eme_r && alt_ovr.toggle_override_en != 8'h00);
  c_slverr: cover property (axi_rsp.bvalid && axi_rsp.bresp == `PPOM_RESP_SLVERR);
endmodule

bind ppom_port_mux ppom_port_mux_monitor mon (.clk(clk), .resetn(resetn), .ce(ce), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .alt_ovr(alt_ovr), .mem_req(mem_req), .sleep(sleep), .pad_in(pad_in), .pad(pad),
  .alt_raw_input(alt_raw_input), .analog_pad_link(analog_pad_link));
